// File: core/sips_pkg.sv
// constants and types for the sleep and idle power sequencer
package sips_pkg;

    // timing at the 200 MHz bus clock
    localparam int CLK_NS = 5;
    localparam int VREG_NS = 10_000;
    localparam int LOCK_NS = 20_000_000;
    localparam int CLOCK_FAIL_MONITOR_NS = 100_000;
    localparam int VREG_CYC = (VREG_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOCK_CYC = (LOCK_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLOCK_FAIL_MONITOR_CYC = (CLOCK_FAIL_MONITOR_NS + CLK_NS - 1) / CLK_NS;
    localparam int OST_PERIODS = 1024;
    localparam int CNT_W = 23;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OSC = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;

    // control fields
    localparam int CTRL_W = 4;
    localparam int CTRL_WDT = 0;
    localparam int CTRL_VREG = 1;
    localparam int CTRL_MON = 2;
    localparam int CTRL_SECONDARY_OSCILLATOR = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h2;

    // reset control register fields
    localparam int STAT_W = 4;
    localparam int STAT_SLEEP = 0;
    localparam int STAT_IDLE = 1;
    localparam int STAT_WATCHDOG_TIMEOUT_FLAG = 2;
    localparam int STAT_TRAP = 3;

    // clock source codes
    localparam int SRC_W = 3;
    localparam logic [SRC_W-1:0] SRC_FRC = 3'h0;
    localparam logic [SRC_W-1:0] SRC_FRCPLL = 3'h1;
    localparam logic [SRC_W-1:0] SRC_EC = 3'h2;
    localparam logic [SRC_W-1:0] SRC_ECPLL = 3'h3;
    localparam logic [SRC_W-1:0] SRC_XT = 3'h4;
    localparam logic [SRC_W-1:0] SRC_HS = 3'h5;
    localparam logic [SRC_W-1:0] SRC_XTPLL = 3'h6;
    localparam logic [SRC_W-1:0] SRC_SECONDARY_OSCILLATOR = 3'h7;

    // wake stage levels
    localparam logic [1:0] LVL_VREG = 2'h0;
    localparam logic [1:0] LVL_OST = 2'h1;
    localparam logic [1:0] LVL_LOCK = 2'h2;
    localparam logic [1:0] LVL_CLOCK_FAIL_MONITOR = 2'h3;

    typedef enum logic [7:0] {
        ST_RUN = 8'h01,
        ST_IDLE = 8'h02,
        ST_SLEEP = 8'h04,
        ST_VREG = 8'h08,
        ST_OST = 8'h10,
        ST_LOCK = 8'h20,
        ST_CLOCK_FAIL_MONITOR = 8'h40,
        ST_FIN = 8'h80
    } sips_state_t;

endpackage

// File: core/sips_sequencer.sv
// sleep and idle power sequencer with apb registers
// Operation
// R1 - sleep stops cpu, clock, system peripherals
// R2 - idle stops only the cpu
// R3 - wake on interrupt, watchdog or reset
// R4 - sleep turns on-chip oscillator off
// R5 - clock monitor off during sleep
// R6 - low power rc runs if watchdog on
// R7 - brownout detector stays on with regulator
// R8 - watchdog cleared before entering sleep
// R9 - change detect and external-clock peripherals run
// R10 - wake restarts clock source used at entry
// R11 - regulator delay when regulator enabled
// R12 - 1024 oscillator periods for crystal sources
// R13 - pll lock wait after start-up count
// R14 - no oscillator delay for running sources
// R15 - monitor delay for stopped crystal or pll; the code gives FRCPLL no monitor delay
// R16 - monitor supervises only after its delay
// R17 - unstable clock with monitor: trap, fast rc
// R18 - unstable clock without monitor: hold cpu
// R19 - software selects oscillator when unlocked
// R20 - wake sets sleep flag; power-on clears
// R21 - watchdog wake sets flags, resumes, no reset
// R22 - vector if priority above cpu; zero ignored
// R23 - coincident interrupt waits for mode entry
// R24 - wake stages run in order, then release
`timescale 1ns/1ps
`default_nettype none

module sips_sequencer
    import sips_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_CYC,
    parameter int CLOCK_FAIL_MONITOR_CYCLES = CLOCK_FAIL_MONITOR_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu and interrupt side
    input wire logic power_save_instruction,
    input wire logic save_sleep_operand,
    input wire logic dev_reset_req,
    input wire logic irq_pending,
    input wire logic [2:0] irq_priority,
    input wire logic [2:0] cpu_priority,
    // oscillator, watchdog and strap inputs
    input wire logic wdt_timeout,
    input wire logic osc_stable,
    input wire logic osc_period_toggle,
    input wire logic cfg_locked,
    // power and clock controls
    output logic cpu_run,
    output logic sysclk_en,
    output logic periph_clk_en,
    output logic ext_periph_en,
    output logic low_power_rc_clock_en,
    output logic brownout_detector_en,
    output logic monitor_active,
    output logic wdt_clear,
    output logic [2:0] sysclk_sel,
    output logic clock_fail_trap,
    output logic cpu_vector
);

    sips_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [STAT_W-1:0] stat_q, stat_set, stat_clr;
    logic [SRC_W-1:0] saved_src_q;
    logic wake_vec_q;
    logic [1:0] wdt_sy_q, osc_sy_q, tck_sy_q, lock_sy_q;
    logic wdt_s3_q, tck_s3_q;
    logic wdt_ev, osc_tick, osc_ok, cfg_lock;
    logic irq_wake, cnt_zero, trap_now, wake_now, wr_en;
    logic wdt_on, mon_on, secondary_oscillator_kept, vec_now;

    // two-flop synchronisers for foreign inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_sy_q <= 2'h0;
            osc_sy_q <= 2'h0;
            tck_sy_q <= 2'h0;
            lock_sy_q <= 2'h0;
            wdt_s3_q <= 1'b0;
            tck_s3_q <= 1'b0;
        end else begin
            wdt_sy_q <= {wdt_sy_q[0], wdt_timeout};
            osc_sy_q <= {osc_sy_q[0], osc_stable};
            tck_sy_q <= {tck_sy_q[0], osc_period_toggle};
            lock_sy_q <= {lock_sy_q[0], cfg_locked};
            wdt_s3_q <= wdt_sy_q[1];
            tck_s3_q <= tck_sy_q[1];
        end
    end

    assign wdt_ev = wdt_sy_q[1] & ~wdt_s3_q;
    assign osc_tick = tck_sy_q[1] ^ tck_s3_q;
    assign osc_ok = osc_sy_q[1];
    assign cfg_lock = lock_sy_q[1];
    assign wdt_on = ctrl_q[CTRL_WDT];
    assign mon_on = ctrl_q[CTRL_MON];
    assign secondary_oscillator_kept = (saved_src_q == SRC_SECONDARY_OSCILLATOR) && ctrl_q[CTRL_SECONDARY_OSCILLATOR];
    // R22 priority zero cannot wake
    assign irq_wake = irq_pending && (irq_priority != 3'h0);
    assign cnt_zero = (cnt_q == '0);
    // R22 vector only above cpu priority
    assign vec_now = irq_wake && !dev_reset_req && (irq_priority > cpu_priority);

    function automatic logic is_xtal(input logic [SRC_W-1:0] s);
        return (s == SRC_XT) || (s == SRC_HS) || (s == SRC_XTPLL) || (s == SRC_SECONDARY_OSCILLATOR);
    endfunction

    function automatic logic is_pll(input logic [SRC_W-1:0] s);
        return (s == SRC_FRCPLL) || (s == SRC_ECPLL) || (s == SRC_XTPLL);
    endfunction

    // next wake stage after the given level
    function automatic sips_state_t after_stage(input logic [1:0] lvl);
        sips_state_t r;
        r = ST_FIN;
        // R15 monitor delay for stopped crystal or pll sources, but none for FRCPLL
        if (lvl < LVL_CLOCK_FAIL_MONITOR && mon_on && !secondary_oscillator_kept && saved_src_q != SRC_FRCPLL
            && (is_xtal(saved_src_q) || is_pll(saved_src_q)))
            r = ST_CLOCK_FAIL_MONITOR;
        // R13 lock wait follows start-up count
        if (lvl < LVL_LOCK && is_pll(saved_src_q))
            r = ST_LOCK;
        // R14 running or rc sources skip start-up
        if (lvl < LVL_OST && is_xtal(saved_src_q) && !secondary_oscillator_kept)
            r = ST_OST;
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] stage_len(input sips_state_t s);
        logic [CNT_W-1:0] n;
        n = '0;
        if (s == ST_VREG)
            n = CNT_W'(VREG_CYC - 1);
        if (s == ST_OST)
            n = CNT_W'(OST_PERIODS - 1);
        if (s == ST_LOCK)
            n = CNT_W'(LOCK_CYCLES - 1);
        if (s == ST_CLOCK_FAIL_MONITOR)
            n = CNT_W'(CLOCK_FAIL_MONITOR_CYCLES - 1);
        return n;
    endfunction

    // R24 stages in order, release after last
    always_comb begin
        state_d = state_q;
        if (dev_reset_req) begin
            state_d = ST_RUN;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    if (power_save_instruction)
                        state_d = save_sleep_operand ? ST_SLEEP : ST_IDLE;
                end
                // R3 idle wake sources
                ST_IDLE: begin
                    if (irq_wake || wdt_ev)
                        state_d = ST_RUN;
                end
                // R11 regulator delay only if enabled
                ST_SLEEP: begin
                    if (irq_wake || wdt_ev)
                        state_d = ctrl_q[CTRL_VREG] ? ST_VREG : after_stage(LVL_VREG);
                end
                ST_VREG: begin
                    if (cnt_zero)
                        state_d = after_stage(LVL_VREG);
                end
                // R12 count oscillator periods
                ST_OST: begin
                    if (cnt_zero && osc_tick)
                        state_d = after_stage(LVL_OST);
                end
                ST_LOCK: begin
                    if (cnt_zero)
                        state_d = after_stage(LVL_LOCK);
                end
                ST_CLOCK_FAIL_MONITOR: begin
                    if (cnt_zero)
                        state_d = after_stage(LVL_CLOCK_FAIL_MONITOR);
                end
                // R18 hold cpu until stable
                ST_FIN: begin
                    if (osc_ok || mon_on)
                        state_d = ST_RUN;
                end
                default: state_d = ST_RUN;
            endcase
        end
    end

    // R17 unstable clock with monitor
    assign trap_now = (state_q == ST_FIN) && !osc_ok && mon_on && !dev_reset_req;
    assign wake_now = (state_q == ST_SLEEP || state_q == ST_IDLE) && state_d != state_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_q <= ST_RUN;
        else
            state_q <= state_d;
    end

    // stage counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_q <= '0;
        else if (state_d != state_q)
            cnt_q <= stage_len(state_d);
        else if (!cnt_zero && (state_q != ST_OST || osc_tick))
            cnt_q <= cnt_q - CNT_W'(1);
    end

    // wake cause for vectoring
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wake_vec_q <= 1'b0;
        else if (wake_now)
            wake_vec_q <= vec_now;
    end

    // clock source selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysclk_sel <= SRC_FRC;
            saved_src_q <= SRC_FRC;
        end else if (trap_now) begin
            // R17 fall back to fast rc
            sysclk_sel <= SRC_FRC;
        end else if (state_q == ST_RUN && state_d == ST_SLEEP) begin
            // R10 remember source at entry
            saved_src_q <= sysclk_sel;
        end else if (state_q == ST_SLEEP && state_d != ST_SLEEP) begin
            // R10 restart remembered source
            sysclk_sel <= saved_src_q;
        end else if (wr_en && paddr == ADDR_OSC && !cfg_lock
                     && (state_q == ST_RUN || state_q == ST_IDLE)) begin
            // R19 unlocked selection write
            sysclk_sel <= pwdata[SRC_W-1:0];
        end
    end

    // power and clock outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_run <= 1'b1;
            sysclk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            ext_periph_en <= 1'b1;
            low_power_rc_clock_en <= 1'b0;
            brownout_detector_en <= 1'b1;
            monitor_active <= 1'b0;
            wdt_clear <= 1'b0;
            clock_fail_trap <= 1'b0;
            cpu_vector <= 1'b0;
        end else begin
            // R1 cpu runs only in run state
            cpu_run <= (state_d == ST_RUN);
            // R4 on-chip oscillator off in sleep
            sysclk_en <= (state_d != ST_SLEEP) || secondary_oscillator_kept;
            // R2 idle keeps system peripherals
            periph_clk_en <= (state_d == ST_RUN) || (state_d == ST_IDLE);
            // R9 pin-clocked logic always alive
            ext_periph_en <= 1'b1;
            // R6 rc clock follows watchdog, and also runs in idle when the monitor is on
            low_power_rc_clock_en <= wdt_on || (mon_on && state_d == ST_IDLE);
            // R7 detector follows regulator
            brownout_detector_en <= ctrl_q[CTRL_VREG];
            // R16 monitor only after wake delays
            monitor_active <= mon_on && (state_d == ST_RUN || state_d == ST_IDLE);
            // R8 watchdog cleared on entry
            wdt_clear <= wdt_on && (state_q == ST_RUN) && (state_d != ST_RUN);
            clock_fail_trap <= trap_now;
            // idle wakes and resumes on one edge, so use the live cause then
            cpu_vector <= (wake_now ? vec_now : wake_vec_q)
                          && state_q != ST_RUN && state_d == ST_RUN
                          && !trap_now && !dev_reset_req;
        end
    end

    // status flag sets and clears
    always_comb begin
        stat_set = '0;
        // R20 sleep flag on any wake from sleep
        stat_set[STAT_SLEEP] = (state_q == ST_SLEEP) && wake_now;
        stat_set[STAT_IDLE] = (state_q == ST_IDLE) && wake_now;
        // R21 watchdog wake sets flag, no reset
        stat_set[STAT_WATCHDOG_TIMEOUT_FLAG] = wdt_ev && wake_now;
        stat_set[STAT_TRAP] = trap_now;
        stat_clr = (wr_en && paddr == ADDR_STAT) ? pwdata[STAT_W-1:0] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            stat_q <= '0;
        else
            stat_q <= (stat_q & ~stat_clr) | stat_set;
    end

    // apb slave, zero wait states
    assign wr_en = psel && penable && pwrite && pready;

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_OSC) || (a == ADDR_STAT) || (a == ADDR_STATE);
    endfunction

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == ADDR_CTRL)
            w[CTRL_W-1:0] = ctrl_q;
        if (a == ADDR_OSC)
            w[SRC_W-1:0] = sysclk_sel;
        if (a == ADDR_STAT)
            w[STAT_W-1:0] = stat_q;
        if (a == ADDR_STATE)
            w = {23'h00_0000, osc_ok, state_q};
        return w;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !is_mapped(paddr);
            prdata <= (psel && !penable && !pwrite) ? rd_word(paddr) : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_q <= CTRL_RST;
        else if (wr_en && paddr == ADDR_CTRL)
            ctrl_q <= pwdata[CTRL_W-1:0];
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence sleep_exit_s;
        state_q == ST_SLEEP ##1 state_q == ST_VREG;
    endsequence

    sleep_gating_a: assert property ( // R1
        state_q == ST_SLEEP |-> !cpu_run && !periph_clk_en && !monitor_active)
        else $error("sleep left cpu or peripherals clocked");
    idle_clocks_a: assert property ( // R2
        state_q == ST_IDLE |-> !cpu_run && sysclk_en && periph_clk_en)
        else $error("idle stopped the system clock");
    wdt_clear_a: assert property ( // R8
        state_q == ST_RUN && state_d == ST_SLEEP && wdt_on |=> wdt_clear ##1 !wdt_clear)
        else $error("watchdog not cleared on sleep entry");
    rc_alive_a: assert property ( // R6
        state_q == ST_SLEEP && wdt_on |-> low_power_rc_clock_en)
        else $error("rc clock stopped with watchdog on");
    vreg_load_a: assert property ( // R11
        sleep_exit_s |-> cnt_q == CNT_W'(VREG_CYC - 1) && ctrl_q[CTRL_VREG])
        else $error("regulator delay loaded wrong");
    lock_order_a: assert property ( // R24
        state_q == ST_LOCK && state_d != ST_LOCK && !dev_reset_req
        |=> state_q == ST_CLOCK_FAIL_MONITOR || state_q == ST_FIN)
        else $error("pll lock stage left out of order");
    trap_frc_a: assert property ( // R17
        trap_now |=> clock_fail_trap && sysclk_sel == SRC_FRC && stat_q[STAT_TRAP])
        else $error("clock fail trap without fast rc switch");
    hold_cpu_a: assert property ( // R18
        state_q == ST_FIN && !osc_ok && !mon_on && !dev_reset_req
        |=> state_q == ST_FIN && !cpu_run)
        else $error("cpu released before oscillator stable");
    wdt_wake_a: assert property ( // R21
        state_q == ST_SLEEP && wdt_ev && !dev_reset_req
        |=> stat_q[STAT_WATCHDOG_TIMEOUT_FLAG] && stat_q[STAT_SLEEP] && !cpu_vector)
        else $error("watchdog wake flags missing");
    restore_src_a: assert property ( // R10
        state_q == ST_SLEEP && state_d != ST_SLEEP |=> sysclk_sel == $past(saved_src_q))
        else $error("wake restarted another clock source");

endmodule

`default_nettype wire

// File: sim/sips_osc_model.sv
// behavioural oscillator partner: runs while enabled, settles after a start count
`timescale 1ns/1ps
`default_nettype none

module sips_osc_model #(
    parameter int START_CYC = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // enable from the sequencer, slow start request from the bench
    input wire logic sysclk_en,
    input wire logic slow,
    // oscillator status
    output logic osc_stable,
    output logic osc_period_toggle
);
    int cnt_q;

    // stopped oscillator: no periods, never reports stable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 0;
            osc_stable <= 1'b0;
            osc_period_toggle <= 1'b0;
        end else if (!sysclk_en) begin
            cnt_q <= 0;
            osc_stable <= 1'b0;
        end else begin
            osc_period_toggle <= ~osc_period_toggle;
            if (cnt_q < START_CYC) begin
                cnt_q <= cnt_q + 1;
            end
            osc_stable <= !slow && (cnt_q >= START_CYC);
        end
    end
endmodule

`default_nettype wire

// File: sim/sleep_idle_power_sequencer_tb.sv
// self-checking bench for the sleep and idle power sequencer
`timescale 1ns/1ps
`default_nettype none

module sleep_idle_power_sequencer_tb;
    import sips_pkg::*;
    localparam int LOCK_N = 20;
    localparam int CLOCK_FAIL_MONITOR_N = 10;
    localparam int START_N = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic power_save_instruction = 1'b0, save_sleep_operand = 1'b0, dev_reset_req = 1'b0;
    logic irq_pending = 1'b0, wdt_timeout = 1'b0, cfg_locked = 1'b0, slow = 1'b0;
    logic [2:0] irq_priority = 3'h0;
    logic [2:0] cpu_priority = 3'h1;
    logic [31:0] prdata;
    logic [2:0] sysclk_sel;
    logic pready, pslverr, cpu_run, sysclk_en, periph_clk_en, ext_periph_en;
    logic low_power_rc_clock_en, brownout_detector_en, monitor_active, wdt_clear;
    logic clock_fail_trap, cpu_vector, osc_stable, osc_period_toggle;
    int num_errors = 0, checks_done = 0, cyc = 0, n;
    logic [31:0] rd;
    logic er, vec, trap;

    always #2.5 pclk = ~pclk;

    sips_sequencer #(.LOCK_CYCLES(LOCK_N), .CLOCK_FAIL_MONITOR_CYCLES(CLOCK_FAIL_MONITOR_N)) sips_sequencer_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .power_save_instruction, .save_sleep_operand, .dev_reset_req,
        .irq_pending, .irq_priority, .cpu_priority, .wdt_timeout, .osc_stable,
        .osc_period_toggle, .cfg_locked, .cpu_run, .sysclk_en, .periph_clk_en,
        .ext_periph_en, .low_power_rc_clock_en, .brownout_detector_en, .monitor_active,
        .wdt_clear, .sysclk_sel, .clock_fail_trap, .cpu_vector);

    sips_osc_model #(.START_CYC(START_N)) sips_osc_model_inst (
        .pclk, .presetn, .sysclk_en, .slow, .osc_stable, .osc_period_toggle);

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        rd = prdata;
        er = pslverr;
        chk("apb_ready", pready, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic psave(input logic s, input logic with_irq);
        @(posedge pclk);
        power_save_instruction <= 1'b1;
        save_sleep_operand <= s;
        irq_pending <= with_irq;
        @(posedge pclk);
        power_save_instruction <= 1'b0;
        #1;
    endtask

    task automatic wait_run(input int lim);
        n = 0;
        vec = 1'b0;
        trap = 1'b0;
        do begin
            tick(1);
            n++;
            vec |= cpu_vector;
            trap |= clock_fail_trap;
        end while (cpu_run !== 1'b1 && n < lim);
        tick(1);
        vec |= cpu_vector;
        trap |= clock_fail_trap;
        chk("woke", cpu_run, 1'b1);
    endtask

    task automatic t_reset;
        chk("rst_outs", {cpu_run, sysclk_en, periph_clk_en, ext_periph_en,
            low_power_rc_clock_en, brownout_detector_en, monitor_active}, 7'b1111010);
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        chk("rst_ctrl", rd, CTRL_RST);
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk("rst_stat", rd, 32'h0000_0000);
    endtask

    task automatic t_regs;
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped_err", er, 1'b1);
        chk("unmapped_rd", rd, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, ADDR_OSC, 32'(i));
            apb(1'b0, ADDR_OSC, 32'h0000_0000);
            chk("osc_sel", rd, 32'(i));
        end
        cfg_locked <= 1'b1;
        tick(4);
        apb(1'b1, ADDR_OSC, 32'(SRC_HS));
        apb(1'b0, ADDR_OSC, 32'h0000_0000);
        chk("osc_locked", rd, 32'(SRC_SECONDARY_OSCILLATOR));
        cfg_locked <= 1'b0;
        tick(4);
        apb(1'b1, ADDR_OSC, 32'(SRC_FRC));
    endtask

    task automatic t_idle;
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        irq_priority <= 3'h3;
        psave(1'b0, 1'b1);
        chk("idle_outs", {cpu_run, sysclk_en, periph_clk_en, ext_periph_en,
            low_power_rc_clock_en, brownout_detector_en, monitor_active}, 7'b0111100);
        chk("idle_wdt_clr", wdt_clear, 1'b1);
        wait_run(20);
        chk("idle_fast", n <= 2, 1'b1);
        chk("idle_vec", vec, 1'b1);
        irq_pending <= 1'b0;
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk("idle_flag", rd, 32'h0000_0001 << STAT_IDLE);
        apb(1'b1, ADDR_STAT, 32'h0000_000F);
    endtask

    task automatic t_sleep_ec;
        apb(1'b1, ADDR_CTRL, 32'h0000_0003);
        apb(1'b1, ADDR_OSC, 32'(SRC_EC));
        irq_priority <= 3'h0;
        psave(1'b1, 1'b1);
        chk("sleep_outs", {cpu_run, sysclk_en, periph_clk_en, ext_periph_en,
            low_power_rc_clock_en, brownout_detector_en, monitor_active}, 7'b0001110);
        chk("sleep_wdt_clr", wdt_clear, 1'b1);
        tick(30);
        chk("pri0_asleep", cpu_run, 1'b0);
        wdt_timeout <= 1'b1;
        wait_run(5000);
        chk("vreg_min", n >= VREG_CYC, 1'b1);
        chk("ec_no_osc", n <= VREG_CYC + 20, 1'b1);
        chk("ec_restart", sysclk_sel, SRC_EC);
        chk("wdt_no_vec", vec, 1'b0);
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk("wdt_flags", rd, (32'h0000_0001 << STAT_SLEEP) | (32'h0000_0001 << STAT_WATCHDOG_TIMEOUT_FLAG));
        wdt_timeout <= 1'b0;
        irq_pending <= 1'b0;
        apb(1'b1, ADDR_STAT, 32'h0000_000F);
    endtask

    task automatic t_sleep_trap;
        apb(1'b1, ADDR_CTRL, 32'h0000_0004);
        apb(1'b1, ADDR_OSC, 32'(SRC_XTPLL));
        slow <= 1'b1;
        irq_priority <= 3'h2;
        psave(1'b1, 1'b0);
        chk("mon_sleep", {cpu_run, sysclk_en, periph_clk_en, ext_periph_en,
            low_power_rc_clock_en, brownout_detector_en, monitor_active}, 7'b0001000);
        irq_pending <= 1'b1;
        wait_run(5000);
        chk("stage_sum", n >= OST_PERIODS + LOCK_N + CLOCK_FAIL_MONITOR_N, 1'b1);
        chk("trap_seen", trap, 1'b1);
        chk("trap_frc", sysclk_sel, SRC_FRC);
        tick(2);
        chk("mon_after", monitor_active, 1'b1);
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk("trap_flags", rd, (32'h0000_0001 << STAT_SLEEP) | (32'h0000_0001 << STAT_TRAP));
        irq_pending <= 1'b0;
        slow <= 1'b0;
        apb(1'b1, ADDR_STAT, 32'h0000_000F);
    endtask

    task automatic t_hold;
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        apb(1'b1, ADDR_OSC, 32'(SRC_XT));
        slow <= 1'b1;
        psave(1'b1, 1'b0);
        irq_pending <= 1'b1;
        tick(1500);
        chk("held_asleep", cpu_run, 1'b0);
        slow <= 1'b0;
        wait_run(100);
        chk("hold_no_trap", trap, 1'b0);
        chk("hold_vec", vec, 1'b1);
        irq_pending <= 1'b0;
        apb(1'b1, ADDR_OSC, 32'(SRC_FRC));
        apb(1'b1, ADDR_STAT, 32'h0000_000F);
    endtask

    task automatic t_devrst;
        psave(1'b1, 1'b0);
        tick(3);
        chk("rst_asleep", cpu_run, 1'b0);
        @(posedge pclk);
        dev_reset_req <= 1'b1;
        @(posedge pclk);
        dev_reset_req <= 1'b0;
        wait_run(5);
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        chk("rst_flag", rd, 32'h0000_0001 << STAT_SLEEP);
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        t_reset();
        t_regs();
        t_idle();
        t_sleep_ec();
        t_sleep_trap();
        t_hold();
        t_devrst();
        end_of_test();
    end
endmodule

`default_nettype wire
